/* hw/gp_map.svh */
`ifndef GP_MAP_SVH
`define GP_MAP_SVH

// Register word width seen by software
`define GP_REG_W 32

// Port 0 geometry
`define GP_P0_PINS 32
`define GP_P0_LSB 0

// Port 1 geometry
`define GP_P1_PINS 28
`define GP_P1_LSB 0

// Port 5 geometry
`define GP_P5_PINS 2
`define GP_P5_LSB 18

// Reset values
`define GP_OUT_RST 1'h0
`define GP_IN_RST 1'h0

`endif

/* hw/gp_pkg.sv */
package gp_pkg;

	// Per-pin direction encoding
	typedef enum logic
	{
		gp_dir_in = 1'h0,
		gp_dir_out = 1'h1
	} gp_dir_t;

endpackage

/* hw/gp_port.sv */
`timescale 1ns/1ps
`include "gp_map.svh"

module gp_port #(
	parameter int PINS = `GP_P0_PINS,
	parameter int LSB = `GP_P0_LSB
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Branch clock gate
	input wire logic clk_en,
	// Direction register write
	input wire logic dir_wr,
	input wire logic [`GP_REG_W-1:0] dir_wdata,
	// Output register write
	input wire logic out_wr,
	input wire logic [`GP_REG_W-1:0] out_wdata,
	// Pins
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	// Readback
	output logic [`GP_REG_W-1:0] dir_rd,
	output logic [`GP_REG_W-1:0] out_rd,
	output logic [`GP_REG_W-1:0] in_rd
);

	////////////////////////////////////////////////////////////////////////////////

	// Place pin bits at their register positions, zeros elsewhere
	function automatic logic [`GP_REG_W-1:0] place(input logic [PINS-1:0] v);
		logic [`GP_REG_W-1:0] r;
		r = '0;
		for (int i = 0; i < PINS; i++)
		begin
			r[LSB+i] = v[i];
		end
		return r;
	endfunction

	// Pick pin bits out of a register word
	function automatic logic [PINS-1:0] pick(input logic [`GP_REG_W-1:0] w);
		logic [PINS-1:0] r;
		r = '0;
		for (int i = 0; i < PINS; i++)
		begin
			r[i] = w[LSB+i];
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	// Only two control registers per port
	logic [PINS-1:0] dir_ff;
	logic [PINS-1:0] out_ff;
	logic [PINS-1:0] sync1_ff;
	logic [PINS-1:0] sync2_ff;
	logic [PINS-1:0] nxt_dir;
	logic [PINS-1:0] nxt_out;
	logic [PINS-1:0] nxt_sync1;
	logic [PINS-1:0] nxt_sync2;

	// A gated branch clock is modelled as an enable: nothing but reset moves while off
	always_comb
	begin
		nxt_dir = dir_ff;
		nxt_out = out_ff;
		nxt_sync1 = sync1_ff;
		nxt_sync2 = sync2_ff;
		if (clk_en)
		begin
			if (dir_wr)
				nxt_dir = pick(dir_wdata);
			// Independent of direction, so open drain is a direction toggle
			if (out_wr)
				nxt_out = pick(out_wdata);
			nxt_sync1 = pin_in;
			nxt_sync2 = sync1_ff;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			dir_ff <= {PINS{gp_pkg::gp_dir_in}};
			out_ff <= {PINS{`GP_OUT_RST}};
			sync1_ff <= {PINS{`GP_IN_RST}};
			sync2_ff <= {PINS{`GP_IN_RST}};
		end
		else
		begin
			dir_ff <= nxt_dir;
			out_ff <= nxt_out;
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Driver enabled only for output pins; input pins float
	assign pin_oe = dir_ff;
	assign pin_out = out_ff;
	assign dir_rd = place(dir_ff);
	assign out_rd = place(out_ff);
	// Input readback ignores direction; unused positions read zero
	assign in_rd = place(sync2_ff);

endmodule

/* hw/gp_top.sv */
`timescale 1ns/1ps
`include "gp_map.svh"

module gp_top #(
	parameter int P0_PINS = `GP_P0_PINS,
	parameter int P1_PINS = `GP_P1_PINS,
	parameter int P5_PINS = `GP_P5_PINS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Port 0 branch clock gate
	input wire logic p0_clk_en,
	// Port 0 register writes
	input wire logic p0_dir_wr,
	input wire logic [`GP_REG_W-1:0] p0_dir_wdata,
	input wire logic p0_out_wr,
	input wire logic [`GP_REG_W-1:0] p0_out_wdata,
	// Port 0 pins
	input wire logic [P0_PINS-1:0] p0_pin_in,
	output logic [P0_PINS-1:0] p0_pin_out,
	output logic [P0_PINS-1:0] p0_pin_oe,
	// Port 0 readback
	output logic [`GP_REG_W-1:0] p0_dir_rd,
	output logic [`GP_REG_W-1:0] p0_out_rd,
	output logic [`GP_REG_W-1:0] p0_in_rd,
	// Port 1 branch clock gate
	input wire logic p1_clk_en,
	// Port 1 register writes
	input wire logic p1_dir_wr,
	input wire logic [`GP_REG_W-1:0] p1_dir_wdata,
	input wire logic p1_out_wr,
	input wire logic [`GP_REG_W-1:0] p1_out_wdata,
	// Port 1 pins
	input wire logic [P1_PINS-1:0] p1_pin_in,
	output logic [P1_PINS-1:0] p1_pin_out,
	output logic [P1_PINS-1:0] p1_pin_oe,
	// Port 1 readback
	output logic [`GP_REG_W-1:0] p1_dir_rd,
	output logic [`GP_REG_W-1:0] p1_out_rd,
	output logic [`GP_REG_W-1:0] p1_in_rd,
	// Port 5 branch clock gate
	input wire logic p5_clk_en,
	// Port 5 register writes
	input wire logic p5_dir_wr,
	input wire logic [`GP_REG_W-1:0] p5_dir_wdata,
	input wire logic p5_out_wr,
	input wire logic [`GP_REG_W-1:0] p5_out_wdata,
	// Port 5 pins, register bits 19:18
	input wire logic [P5_PINS-1:0] p5_pin_in,
	output logic [P5_PINS-1:0] p5_pin_out,
	output logic [P5_PINS-1:0] p5_pin_oe,
	// Port 5 readback
	output logic [`GP_REG_W-1:0] p5_dir_rd,
	output logic [`GP_REG_W-1:0] p5_out_rd,
	output logic [`GP_REG_W-1:0] p5_in_rd
);

	////////////////////////////////////////////////////////////////////////////////

	gp_port #(
		.PINS(P0_PINS),
		.LSB(`GP_P0_LSB)
	) u_port0 (
		.sys_clk(sys_clk),
		.reset(reset),
		.clk_en(p0_clk_en),
		.dir_wr(p0_dir_wr),
		.dir_wdata(p0_dir_wdata),
		.out_wr(p0_out_wr),
		.out_wdata(p0_out_wdata),
		.pin_in(p0_pin_in),
		.pin_out(p0_pin_out),
		.pin_oe(p0_pin_oe),
		.dir_rd(p0_dir_rd),
		.out_rd(p0_out_rd),
		.in_rd(p0_in_rd)
	);

	gp_port #(
		.PINS(P1_PINS),
		.LSB(`GP_P1_LSB)
	) u_port1 (
		.sys_clk(sys_clk),
		.reset(reset),
		.clk_en(p1_clk_en),
		.dir_wr(p1_dir_wr),
		.dir_wdata(p1_dir_wdata),
		.out_wr(p1_out_wr),
		.out_wdata(p1_out_wdata),
		.pin_in(p1_pin_in),
		.pin_out(p1_pin_out),
		.pin_oe(p1_pin_oe),
		.dir_rd(p1_dir_rd),
		.out_rd(p1_out_rd),
		.in_rd(p1_in_rd)
	);

	gp_port #(
		.PINS(P5_PINS),
		.LSB(`GP_P5_LSB)
	) u_port5 (
		.sys_clk(sys_clk),
		.reset(reset),
		.clk_en(p5_clk_en),
		.dir_wr(p5_dir_wr),
		.dir_wdata(p5_dir_wdata),
		.out_wr(p5_out_wr),
		.out_wdata(p5_out_wdata),
		.pin_in(p5_pin_in),
		.pin_out(p5_pin_out),
		.pin_oe(p5_pin_oe),
		.dir_rd(p5_dir_rd),
		.out_rd(p5_out_rd),
		.in_rd(p5_in_rd)
	);

	////////////////////////////////////////////////////////////////////////////////

	localparam logic [`GP_REG_W-1:0] P1_MASK = 32'h0fffffff;
	localparam logic [`GP_REG_W-1:0] P5_MASK = 32'h000c0000;

	// Checks sit on the top ports so they see what the pins see
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	AST_DIR_WRITE: assert property (
		p0_clk_en && p0_dir_wr |=> p0_dir_rd == $past(p0_dir_wdata))
	else $error("port 0 direction write not stored");

	AST_P5_DIR_PER_PIN: assert property (
		p5_clk_en && p5_dir_wr |=> p5_pin_oe == $past(p5_dir_wdata[19:18]))
	else $error("port 5 direction bits not applied per pin");

	AST_TWO_REGS: assert property (
		p0_clk_en && p0_out_wr && !p0_dir_wr |=> $stable(p0_dir_rd)
		&& p0_out_rd == $past(p0_out_wdata))
	else $error("output write disturbed direction register");

	AST_SYNC_P0: assert property (
		!$past(reset) && !$past(reset, 2) && $past(p0_clk_en) && $past(p0_clk_en, 2)
		|-> p0_in_rd == $past(p0_pin_in, 2))
	else $error("port 0 input not seen two cycles later");

	AST_SYNC_P5: assert property (
		!$past(reset) && !$past(reset, 2) && $past(p5_clk_en) && $past(p5_clk_en, 2)
		|-> p5_in_rd[19:18] == $past(p5_pin_in, 2))
	else $error("port 5 input not seen two cycles later");

	AST_RESET_INPUT: assert property (disable iff (1'b0)
		reset |=> p0_pin_oe == '0 && p1_pin_oe == '0 && p5_pin_oe == '0)
	else $error("driver enabled right after reset");

	AST_DRIVE: assert property (
		p0_clk_en && p0_out_wr |=> p0_pin_out == $past(p0_out_wdata))
	else $error("output pin level not the output register");

	AST_FLOAT: assert property (
		p0_clk_en && p0_dir_wr && p0_dir_wdata == '0 |=> (p0_pin_oe == '0)
		and ((p0_clk_en && p0_dir_wr) or (##1 p0_pin_oe == '0)))
	else $error("input pin still driven");

	AST_OUT_HOLD: assert property (
		p0_clk_en && p0_dir_wr && !p0_out_wr |=> $stable(p0_out_rd)
		&& $stable(p0_pin_out))
	else $error("direction change altered output register");

	AST_P0_FULL: assert property (
		p0_clk_en && p0_out_wr && p0_out_wdata == 32'hffffffff
		|=> p0_out_rd == 32'hffffffff)
	else $error("port 0 does not hold all 32 bits");

	AST_P1_MASK: assert property (
		(((p1_dir_rd | p1_out_rd | p1_in_rd) & ~P1_MASK) == '0)
		and (p1_clk_en && p1_dir_wr |=> p1_dir_rd == ($past(p1_dir_wdata) & P1_MASK)))
	else $error("port 1 width wrong");

	AST_P5_MASK: assert property (
		p5_clk_en && p5_out_wr |=> p5_out_rd == ($past(p5_out_wdata) & P5_MASK)
		&& p5_pin_out == $past(p5_out_wdata[19:18]))
	else $error("port 5 bits misplaced");

	AST_GATED: assert property (
		!p1_clk_en |=> $stable(p1_dir_rd) && $stable(p1_out_rd) && $stable(p1_in_rd))
	else $error("port 1 moved with branch clock off");

	AST_GATED_P5: assert property (
		!p5_clk_en |=> $stable(p5_in_rd) && $stable(p5_pin_oe) && $stable(p5_pin_out))
	else $error("port 5 moved with branch clock off");

	AST_IN_ALL: assert property (
		!$past(reset) && !$past(reset, 2) && $past(p1_clk_en) && $past(p1_clk_en, 2)
		|-> p1_in_rd == ({4'h0, $past(p1_pin_in, 2)} & P1_MASK)
		&& (p5_in_rd & ~P5_MASK) == '0)
	else $error("input readback wrong or unused bits set");

	// Main scenarios
	COV_OPEN_DRAIN: cover property (
		p0_clk_en && p0_dir_wr ##1 p0_clk_en && p0_dir_wr ##1 p0_pin_oe == '0);

	COV_P5_DRIVE: cover property (
		p5_clk_en && p5_dir_wr && p5_dir_wdata == P5_MASK ##1 p5_pin_oe == 2'h3);

	COV_GATED_WRITE: cover property (!p1_clk_en && p1_dir_wr);

	COV_MIDRUN_RESET: cover property (disable iff (1'b0) reset && p0_pin_oe == 32'hffffffff);

	COV_SYNC_RISE: cover property ($rose(p0_in_rd[0]));

endmodule

/* dv/gp_board.sv */
`timescale 1ns/1ps
module gp_board #(
	parameter int PINS = 2
) (
	// Device side
	input wire logic [PINS-1:0] pin_out,
	input wire logic [PINS-1:0] pin_oe,
	// Board side
	input wire logic [PINS-1:0] ext_val,
	input wire logic ext_en,
	// Wire level back to device
	output logic [PINS-1:0] pin_in
);
	// Released lines settle at the pull-up, never hold the last value
	always_comb
	begin
		for (int i = 0; i < PINS; i++)
		begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en ? ext_val[i] : 1'h1);
		end
	end
endmodule

/* dv/tb_general_purpose_io_port.sv */
`timescale 1ns/1ps
module tb_general_purpose_io_port;
	typedef struct packed {logic [31:0] dir; logic [31:0] out; logic [31:0] ext;} gp_row_t;
	localparam logic [31:0] MSK [3] = '{32'hffffffff, 32'h0fffffff, 32'h000c0000};
	localparam gp_row_t ROWS [4] = '{
		'{32'h0, 32'hffffffff, 32'ha5a5a5a5},
		'{32'hffffffff, 32'h5a5a5a5a, 32'h0},
		'{32'h0f0f0f0f, 32'h0, 32'hffffffff},
		'{32'hf00c0003, 32'h12345678, 32'h0ff3fffc}};
	logic sys_clk = 1'h0;
	logic reset = 1'h1;
	logic [2:0] en = 3'h7;
	logic dwr = 1'h0;
	logic owr = 1'h0;
	logic xen = 1'h1;
	logic [31:0] dwd = 32'h0;
	logic [31:0] owd = 32'h0;
	logic [31:0] ext = 32'h0;
	logic [31:0] dr [3];
	logic [31:0] orr [3];
	logic [31:0] ir [3];
	logic [31:0] ov [3];
	logic [31:0] pv [3];
	logic [31:0] po0, oe0, pi0;
	logic [27:0] po1, oe1, pi1;
	logic [1:0] po5, oe5, pi5;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;

	always #20 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////
	gp_top dut_u (
		.sys_clk, .reset,
		.p0_clk_en(en[0]), .p0_dir_wr(dwr), .p0_dir_wdata(dwd), .p0_out_wr(owr),
		.p0_out_wdata(owd), .p0_pin_in(pi0), .p0_pin_out(po0), .p0_pin_oe(oe0),
		.p0_dir_rd(dr[0]), .p0_out_rd(orr[0]), .p0_in_rd(ir[0]),
		.p1_clk_en(en[1]), .p1_dir_wr(dwr), .p1_dir_wdata(dwd), .p1_out_wr(owr),
		.p1_out_wdata(owd), .p1_pin_in(pi1), .p1_pin_out(po1), .p1_pin_oe(oe1),
		.p1_dir_rd(dr[1]), .p1_out_rd(orr[1]), .p1_in_rd(ir[1]),
		.p5_clk_en(en[2]), .p5_dir_wr(dwr), .p5_dir_wdata(dwd), .p5_out_wr(owr),
		.p5_out_wdata(owd), .p5_pin_in(pi5), .p5_pin_out(po5), .p5_pin_oe(oe5),
		.p5_dir_rd(dr[2]), .p5_out_rd(orr[2]), .p5_in_rd(ir[2])
	);
	gp_board #(.PINS(32)) b0_u (.pin_out(po0), .pin_oe(oe0), .ext_val(ext), .ext_en(xen),
		.pin_in(pi0));
	gp_board #(.PINS(28)) b1_u (.pin_out(po1), .pin_oe(oe1), .ext_val(ext[27:0]),
		.ext_en(xen), .pin_in(pi1));
	gp_board #(.PINS(2)) b5_u (.pin_out(po5), .pin_oe(oe5), .ext_val(ext[19:18]),
		.ext_en(xen), .pin_in(pi5));
	// Pin views placed at register bit positions
	assign ov[0] = oe0;
	assign ov[1] = {4'h0, oe1};
	assign ov[2] = {12'h0, oe5, 18'h0};
	assign pv[0] = po0;
	assign pv[1] = {4'h0, po1};
	assign pv[2] = {12'h0, po5, 18'h0};

	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_all(input logic [31:0] ed, input logic [31:0] eo, input logic [31:0] ex);
		for (int p = 0; p < 3; p++)
		begin
			chk("dir_rd", ed & MSK[p], dr[p]);
			chk("out_rd", eo & MSK[p], orr[p]);
			chk("pin_oe", ed & MSK[p], ov[p]);
			chk("pin_out", eo & MSK[p], pv[p]);
			chk("in_rd", ((ed & eo) | (~ed & ex)) & MSK[p], ir[p]);
		end
	endtask

	// Write both registers, then let the pins pass the synchronizer
	task automatic wr(input logic [31:0] d, input logic [31:0] o, input logic [31:0] x);
		@(posedge sys_clk);
		dwr <= 1'h1;
		owr <= 1'h1;
		dwd <= d;
		owd <= o;
		ext <= x;
		@(posedge sys_clk);
		dwr <= 1'h0;
		owr <= 1'h0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 300)
		begin
			fail_count++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge sys_clk);
		reset <= 1'h0;
		#1;
		chk_all(32'h0, 32'h0, 32'h0);
		for (int r = 0; r < 4; r++)
		begin
			wr(ROWS[r].dir, ROWS[r].out, ROWS[r].ext);
			chk_all(ROWS[r].dir, ROWS[r].out, ROWS[r].ext);
		end
		$display("Test rows done");
		// Gated branch clock: writes must be dropped
		@(posedge sys_clk);
		en <= 3'h0;
		wr(~ROWS[3].dir, ~ROWS[3].out, ROWS[3].ext);
		chk_all(ROWS[3].dir, ROWS[3].out, ROWS[3].ext);
		// Only port 1 gated: the other ports must still take writes
		@(posedge sys_clk);
		en <= 3'h5;
		wr(ROWS[1].dir, ROWS[1].out, ROWS[1].ext);
		chk("dir_rd", ROWS[1].dir & MSK[0], dr[0]);
		chk("dir_rd", ROWS[3].dir & MSK[1], dr[1]);
		chk("out_rd", ROWS[1].out & MSK[2], orr[2]);
		@(posedge sys_clk);
		en <= 3'h7;
		$display("Test gate done");
		// Two-edge synchronizer latency, released board reads pull-up
		wr(32'h0, 32'h0, 32'h0);
		@(posedge sys_clk);
		xen <= 1'h0;
		@(posedge sys_clk);
		#1;
		chk("in_rd", 32'h0, ir[0]);
		@(posedge sys_clk);
		#1;
		chk_all(32'h0, 32'h0, 32'hffffffff);
		$display("Test sync done");
		// Open drain: output bit held low, direction toggled back to back
		@(posedge sys_clk);
		dwr <= 1'h1;
		dwd <= 32'hffffffff;
		@(posedge sys_clk);
		dwd <= 32'h0;
		#1;
		chk("pin_oe", 32'hffffffff, ov[0]);
		chk("pin_out", 32'h0, pv[0]);
		@(posedge sys_clk);
		dwr <= 1'h0;
		#1;
		chk("pin_oe", 32'h0, ov[0]);
		chk("pin_out", 32'h0, pv[0]);
		$display("Test drain done");
		// Reset in mid-run drops all drivers
		wr(32'hffffffff, 32'h0, 32'h0);
		@(posedge sys_clk);
		reset <= 1'h1;
		xen <= 1'h1;
		@(posedge sys_clk);
		#1;
		chk_all(32'h0, 32'h0, 32'h0);
		@(posedge sys_clk);
		reset <= 1'h0;
		wr(ROWS[2].dir, ROWS[2].out, ROWS[2].ext);
		chk_all(ROWS[2].dir, ROWS[2].out, ROWS[2].ext);
		$display("Test reset done");
		wrap_up();
	end
endmodule
